/* inc/rreu_pkg.sv */
// rreu_pkg: shared constants and types of the rotate and return execution unit.
// assumes the decoder hands over one operation code per issue cycle.
package rreu_pkg;

  // data path and program counter widths
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned MSB_POS = 7;
  localparam int unsigned LSB_POS = 0;

  // the value written into the global interrupt enable on interrupt_return
  localparam logic GIE_SET_VALUE = 1'b1;

  // reset values of the registered results
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic FLAG_RST = 1'b0;

  // latency from issue to registered result, in clock cycles
  localparam int unsigned EXEC_LATENCY = 1;

  // operation codes accepted by the unit
  typedef enum logic [3:0] {
    RREU_OP_NONE = 4'h0,
    RREU_OP_RETURN_LOAD_ACC = 4'h1,
    RREU_OP_INTERRUPT_RETURN = 4'h2,
    RREU_OP_ROTATE_LEFT_IN_PLACE = 4'h3,
    RREU_OP_ROTATE_LEFT_TO_ACC = 4'h4,
    RREU_OP_ROTATE_LEFT_THROUGH_CARRY = 4'h5,
    RREU_OP_ROTATE_LEFT_CARRY_TO_ACC = 4'h6,
    RREU_OP_ROTATE_RIGHT_IN_PLACE = 4'h7,
    RREU_OP_ROTATE_RIGHT_TO_ACC = 4'h8,
    RREU_OP_ROTATE_RIGHT_THROUGH_CARRY = 4'h9,
    RREU_OP_ROTATE_RIGHT_CARRY_TO_ACC = 4'ha
  } rreu_op_t;

  // all registered state of the top module
  typedef struct packed {
    logic acc_we;
    logic [DATA_W-1:0] acc_data;
    logic mem_we;
    logic [DATA_W-1:0] mem_data;
    logic carry_we;
    logic carry;
    logic stack_pop;
    logic pc_load;
    logic [PC_W-1:0] pc;
    logic gie_set;
    logic irq_take;
    logic done;
    logic illegal;
  } rreu_state_t;

endpackage

/* logic/rreu_rotator.sv */
// rreu_rotator: one-bit rotate left or right, plain or through the carry flag.
// assumes the caller picks the destination; this block is purely combinational.
`timescale 1ns/1ps
module rreu_rotator
  import rreu_pkg::*;
(
  input wire logic rotate_right_i,
  input wire logic through_carry_i,
  input wire logic [DATA_W-1:0] operand_i,
  input wire logic carry_i,
  output logic [DATA_W-1:0] result_o,
  output logic carry_o
);

  logic fill_left;
  logic fill_right;

  // bit that enters the vacated end: own far end, or the old carry
  assign fill_left = through_carry_i ? carry_i : operand_i[MSB_POS];
  assign fill_right = through_carry_i ? carry_i : operand_i[LSB_POS];

  // each result bit comes from its neighbour; ends take the fill bit
  for (genvar b = 0; b < DATA_W; b++) begin : g_bit
    if (b == LSB_POS) begin : g_lsb
      assign result_o[b] = rotate_right_i ? operand_i[b+1] : fill_left;
    end else if (b == MSB_POS) begin : g_msb
      assign result_o[b] = rotate_right_i ? fill_right : operand_i[b-1];
    end else begin : g_mid
      assign result_o[b] = rotate_right_i ? operand_i[b+1] : operand_i[b-1];
    end
  end

  // the bit shifted out becomes the new carry
  assign carry_o = rotate_right_i ? operand_i[LSB_POS] : operand_i[MSB_POS];

endmodule

/* logic/rreu_return_unit.sv */
// rreu_return_unit: program counter restore for the two return operations.
// assumes the stack presents its top entry on stack_pc_i while a return is issued.
`timescale 1ns/1ps
module rreu_return_unit
  import rreu_pkg::*;
(
  input wire logic is_return_i,
  input wire logic is_interrupt_return_i,
  input wire logic irq_pending_i,
  input wire logic [PC_W-1:0] stack_pc_i,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  output logic gie_set_o,
  output logic irq_take_o
);

  logic any_return;

  assign any_return = is_return_i | is_interrupt_return_i;

  // both returns pop; the popped address always goes out on pc_o
  assign stack_pop_o = any_return;
  assign pc_o = stack_pc_i;
  assign gie_set_o = is_interrupt_return_i;

  // on interrupt_return a pending request is serviced first: the popped address is handed to the
  // interrupt controller as the address to push, instead of being jumped to
  assign irq_take_o = is_interrupt_return_i & irq_pending_i;
  assign pc_load_o = any_return & ~irq_take_o;

endmodule

/* logic/rreu_exec_unit.sv */
// rreu_exec_unit: rotate and return execution for the 8-bit core.
// assumes one operation per cycle from the decoder on the same clock, the
// operand already read from data memory, and the carry flag held outside.
`timescale 1ns/1ps
module rreu_exec_unit
  import rreu_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire logic [3:0] op_code_i,
  input wire logic [DATA_W-1:0] mem_operand_i,
  input wire logic [DATA_W-1:0] imm_i,
  input wire logic carry_i,
  input wire logic [PC_W-1:0] stack_pc_i,
  input wire logic irq_pending_i,
  output logic acc_we_o,
  output logic [DATA_W-1:0] acc_data_o,
  output logic mem_we_o,
  output logic [DATA_W-1:0] mem_data_o,
  output logic carry_we_o,
  output logic carry_o,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  output logic gie_set_o,
  output logic irq_take_o,
  output logic done_o,
  output logic illegal_o
);

  rreu_state_t state;
  rreu_state_t next_state;
  rreu_op_t op;

  logic is_ret_acc;
  logic is_interrupt_return;
  logic is_rotate;
  logic rot_right;
  logic rot_carry;
  logic rot_to_acc;
  logic [DATA_W-1:0] rot_result;
  logic rot_carry_out;
  logic ret_pop;
  logic ret_pc_load;
  logic [PC_W-1:0] ret_pc;
  logic ret_gie_set;
  logic ret_irq_take;

  assign op = rreu_op_t'(op_code_i);

  // decode the operation into a few steering bits
  always_comb begin
    is_ret_acc = 1'b0;
    is_interrupt_return = 1'b0;
    is_rotate = 1'b0;
    rot_right = 1'b0;
    rot_carry = 1'b0;
    rot_to_acc = 1'b0;
    if (op_valid_i) begin
      case (op)
        RREU_OP_RETURN_LOAD_ACC: begin
          is_ret_acc = 1'b1;
        end
        RREU_OP_INTERRUPT_RETURN: begin
          is_interrupt_return = 1'b1;
        end
        RREU_OP_ROTATE_LEFT_IN_PLACE: begin
          is_rotate = 1'b1;
        end
        RREU_OP_ROTATE_LEFT_TO_ACC: begin
          is_rotate = 1'b1;
          rot_to_acc = 1'b1;
        end
        RREU_OP_ROTATE_LEFT_THROUGH_CARRY: begin
          is_rotate = 1'b1;
          rot_carry = 1'b1;
        end
        RREU_OP_ROTATE_LEFT_CARRY_TO_ACC: begin
          is_rotate = 1'b1;
          rot_carry = 1'b1;
          rot_to_acc = 1'b1;
        end
        RREU_OP_ROTATE_RIGHT_IN_PLACE: begin
          is_rotate = 1'b1;
          rot_right = 1'b1;
        end
        RREU_OP_ROTATE_RIGHT_TO_ACC: begin
          is_rotate = 1'b1;
          rot_right = 1'b1;
          rot_to_acc = 1'b1;
        end
        RREU_OP_ROTATE_RIGHT_THROUGH_CARRY: begin
          is_rotate = 1'b1;
          rot_right = 1'b1;
          rot_carry = 1'b1;
        end
        RREU_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
          is_rotate = 1'b1;
          rot_right = 1'b1;
          rot_carry = 1'b1;
          rot_to_acc = 1'b1;
        end
        default: begin
          is_rotate = 1'b0;
        end
      endcase
    end
  end

  // shared rotator: one data path serves all eight rotate forms
  rreu_rotator u_rotator (
    .rotate_right_i(rot_right),
    .through_carry_i(rot_carry),
    .operand_i(mem_operand_i),
    .carry_i(carry_i),
    .result_o(rot_result),
    .carry_o(rot_carry_out)
  );

  // program counter restore for both return forms
  rreu_return_unit u_return (
    .is_return_i(is_ret_acc),
    .is_interrupt_return_i(is_interrupt_return),
    .irq_pending_i(irq_pending_i),
    .stack_pc_i(stack_pc_i),
    .stack_pop_o(ret_pop),
    .pc_load_o(ret_pc_load),
    .pc_o(ret_pc),
    .gie_set_o(ret_gie_set),
    .irq_take_o(ret_irq_take)
  );

  // next results; every strobe is a one-cycle pulse, data holds its last value
  always_comb begin
    next_state = state;
    next_state.acc_we = 1'b0;
    next_state.mem_we = 1'b0;
    next_state.carry_we = 1'b0;
    next_state.stack_pop = 1'b0;
    next_state.pc_load = 1'b0;
    next_state.gie_set = 1'b0;
    next_state.irq_take = 1'b0;
    next_state.done = op_valid_i;
    next_state.illegal = op_valid_i & ~is_rotate & ~is_ret_acc & ~is_interrupt_return;
    if (is_ret_acc) begin
      next_state.acc_we = 1'b1;
      next_state.acc_data = imm_i;
    end
    if (is_ret_acc || is_interrupt_return) begin
      next_state.stack_pop = ret_pop;
      next_state.pc_load = ret_pc_load;
      next_state.pc = ret_pc;
      next_state.gie_set = ret_gie_set & GIE_SET_VALUE;
      next_state.irq_take = ret_irq_take;
    end
    if (is_rotate) begin
      // accumulator forms leave memory alone; in-place forms leave acc alone
      next_state.acc_we = rot_to_acc;
      next_state.mem_we = ~rot_to_acc;
      if (rot_to_acc) begin
        next_state.acc_data = rot_result;
      end else begin
        next_state.mem_data = rot_result;
      end
      // only the through-carry forms write the flag; carry_o is updated on every rotate
      next_state.carry_we = rot_carry;
      next_state.carry = rot_carry_out;
    end
  end

  // single register stage: all outputs come straight from these flops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state <= '{acc_we: FLAG_RST, acc_data: DATA_RST, mem_we: FLAG_RST,
                 mem_data: DATA_RST, carry_we: FLAG_RST, carry: FLAG_RST,
                 stack_pop: FLAG_RST, pc_load: FLAG_RST, pc: PC_RST,
                 gie_set: FLAG_RST, irq_take: FLAG_RST, done: FLAG_RST,
                 illegal: FLAG_RST};
    end else begin
      state <= next_state;
    end
  end

  assign acc_we_o = state.acc_we;
  assign acc_data_o = state.acc_data;
  assign mem_we_o = state.mem_we;
  assign mem_data_o = state.mem_data;
  assign carry_we_o = state.carry_we;
  assign carry_o = state.carry;
  assign stack_pop_o = state.stack_pop;
  assign pc_load_o = state.pc_load;
  assign pc_o = state.pc;
  assign gie_set_o = state.gie_set;
  assign irq_take_o = state.irq_take;
  assign done_o = state.done;
  assign illegal_o = state.illegal;

  // checks on the registered results, one cycle after issue
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_ret_acc_load: assert property (
    op_valid_i && op == RREU_OP_RETURN_LOAD_ACC |=> acc_we_o && stack_pop_o
      && acc_data_o == $past(imm_i) && pc_o == $past(stack_pc_i) && pc_load_o && !carry_we_o)
    else $error("return_load_acc did not pop, load acc and resume");

  a_interrupt_return_gie_set: assert property (
    op_valid_i && op == RREU_OP_INTERRUPT_RETURN |=> stack_pop_o && gie_set_o
      && !carry_we_o && !acc_we_o && !mem_we_o)
    else $error("interrupt_return did not pop and set the interrupt enable");

  a_interrupt_return_irq_first: assert property (
    op_valid_i && op == RREU_OP_INTERRUPT_RETURN && irq_pending_i
      |=> irq_take_o && !pc_load_o && pc_o == $past(stack_pc_i))
    else $error("pending interrupt not serviced before resuming");

  a_rl_in_place: assert property (
    op_valid_i && op == RREU_OP_ROTATE_LEFT_IN_PLACE |=> mem_we_o && !acc_we_o
      && !carry_we_o && mem_data_o == {$past(mem_operand_i[6:0]), $past(mem_operand_i[7])})
    else $error("rotate left in place result wrong");

  a_rl_to_acc: assert property (
    op_valid_i && op == RREU_OP_ROTATE_LEFT_TO_ACC |=> acc_we_o && !mem_we_o
      && !carry_we_o && acc_data_o == {$past(mem_operand_i[6:0]), $past(mem_operand_i[7])})
    else $error("rotate left to accumulator result wrong");

  a_rlc_in_place: assert property (
    op_valid_i && op == RREU_OP_ROTATE_LEFT_THROUGH_CARRY |=> mem_we_o && carry_we_o
      && carry_o == $past(mem_operand_i[7])
      && mem_data_o == {$past(mem_operand_i[6:0]), $past(carry_i)})
    else $error("rotate left through carry result wrong");

  a_rlc_to_acc: assert property (
    op_valid_i && op == RREU_OP_ROTATE_LEFT_CARRY_TO_ACC |=> acc_we_o && !mem_we_o
      && carry_we_o && carry_o == $past(mem_operand_i[7])
      && acc_data_o == {$past(mem_operand_i[6:0]), $past(carry_i)})
    else $error("rotate left through carry to accumulator wrong");

  a_rr_in_place: assert property (
    op_valid_i && op == RREU_OP_ROTATE_RIGHT_IN_PLACE |=> mem_we_o && !carry_we_o && !acc_we_o
      && mem_data_o == {$past(mem_operand_i[0]), $past(mem_operand_i[7:1])})
    else $error("rotate right in place result wrong");

  a_rr_to_acc: assert property (
    op_valid_i && op == RREU_OP_ROTATE_RIGHT_TO_ACC |=> acc_we_o && !mem_we_o
      && !carry_we_o && acc_data_o == {$past(mem_operand_i[0]), $past(mem_operand_i[7:1])})
    else $error("rotate right to accumulator result wrong");

  a_rrc_in_place: assert property (
    op_valid_i && op == RREU_OP_ROTATE_RIGHT_THROUGH_CARRY |=> mem_we_o && carry_we_o
      && carry_o == $past(mem_operand_i[0])
      && mem_data_o == {$past(carry_i), $past(mem_operand_i[7:1])})
    else $error("rotate right through carry result wrong");

  a_strobe_single: assert property (
    !op_valid_i |=> !acc_we_o && !mem_we_o && !carry_we_o && !stack_pop_o && !done_o)
    else $error("write strobe without an issued operation");

  a_rrc_to_acc: assert property (
    op_valid_i && op == RREU_OP_ROTATE_RIGHT_CARRY_TO_ACC |=> acc_we_o && !mem_we_o
      && carry_we_o && carry_o == $past(mem_operand_i[0])
      && acc_data_o == {$past(carry_i), $past(mem_operand_i[7:1])})
    else $error("rotate right through carry to accumulator wrong");

  // a plain return never diverts to the interrupt controller, even with a request up
  a_ret_acc_resume: assert property (
    op_valid_i && op == RREU_OP_RETURN_LOAD_ACC |=> !irq_take_o && !gie_set_o
      && !mem_we_o && done_o && !illegal_o)
    else $error("return_load_acc touched interrupt state or memory");

  a_interrupt_return_resume: assert property (
    op_valid_i && op == RREU_OP_INTERRUPT_RETURN && !irq_pending_i
      |=> pc_load_o && !irq_take_o && pc_o == $past(stack_pc_i))
    else $error("interrupt_return did not resume at the popped address");

  // stack and program counter strobes belong to the two return forms alone
  a_return_only: assert property (
    !(op_valid_i && (op == RREU_OP_RETURN_LOAD_ACC || op == RREU_OP_INTERRUPT_RETURN))
      |=> !stack_pop_o && !pc_load_o && !gie_set_o && !irq_take_o)
    else $error("stack or interrupt strobe outside a return");

  // every issue completes next cycle; only code 0 and codes above 4'ha raise illegal
  a_issue_done: assert property (
    op_valid_i |=> done_o && illegal_o == $past(op_code_i > 4'ha || op_code_i == 4'h0))
    else $error("issued operation did not complete or misreported its code");

  // data outputs hold between operations so the core may sample them late
  a_data_hold: assert property (
    !op_valid_i |=> $stable(acc_data_o) && $stable(mem_data_o) && $stable(pc_o))
    else $error("data output changed without an issued operation");

  // every rotate writes exactly one destination, never both and never neither
  a_rot_one_dest: assert property (
    op_valid_i && op_code_i >= 4'h3 && op_code_i <= 4'ha |=> acc_we_o != mem_we_o)
    else $error("rotate wrote both or neither destination");

endmodule

/* dv/rotate_return_exec_unit_bench.sv */
// rotate_return_exec_unit_bench: self-checking bench for rreu_exec_unit.
// assumes the one-cycle registered answer and opcode table of rreu_pkg.
`timescale 1ns/1ps
module rotate_return_exec_unit_bench
  import rreu_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [DATA_W-1:0] mem_operand = 8'h00;
  logic [DATA_W-1:0] imm = 8'h00;
  logic carry = 1'b0;
  logic [PC_W-1:0] stack_pc = 13'h0000;
  logic irq_pending = 1'b0;
  logic acc_we_o, mem_we_o, carry_we_o, carry_o, stack_pop_o, pc_load_o;
  logic gie_set_o, irq_take_o, done_o, illegal_o;
  logic [DATA_W-1:0] acc_data_o, mem_data_o;
  logic [PC_W-1:0] pc_o;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;

  rreu_exec_unit i_rreu_exec_unit (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid), .op_code_i(op_code),
    .mem_operand_i(mem_operand), .imm_i(imm), .carry_i(carry), .stack_pc_i(stack_pc),
    .irq_pending_i(irq_pending), .acc_we_o(acc_we_o), .acc_data_o(acc_data_o),
    .mem_we_o(mem_we_o), .mem_data_o(mem_data_o), .carry_we_o(carry_we_o),
    .carry_o(carry_o), .stack_pop_o(stack_pop_o), .pc_load_o(pc_load_o), .pc_o(pc_o),
    .gie_set_o(gie_set_o), .irq_take_o(irq_take_o), .done_o(done_o), .illegal_o(illegal_o)
  );

  // 200 MHz system clock
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // values are zero-extended so x or z bits still break the match
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one issue cycle; returns just after the edge that registers the answer
  task automatic issue(input logic [3:0] code, input logic [DATA_W-1:0] opnd,
                       input logic [DATA_W-1:0] imm_v, input logic cin,
                       input logic [PC_W-1:0] spc, input logic irq);
    @(posedge clk_sys_i);
    op_valid <= 1'b1;
    op_code <= code;
    mem_operand <= opnd;
    imm <= imm_v;
    carry <= cin;
    stack_pc <= spc;
    irq_pending <= irq;
    @(posedge clk_sys_i);
    op_valid <= 1'b0;
    #1;
  endtask

  // reset clears every registered output, also in mid-run
  task automatic test_reset();
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    chk({acc_we_o, mem_we_o, carry_we_o, carry_o, stack_pop_o, pc_load_o}, 16'h0000);
    chk({gie_set_o, irq_take_o, done_o, illegal_o}, 16'h0000);
    chk({acc_data_o, mem_data_o}, 16'h0000);
    chk(pc_o, 16'h0000);
    $display("test reset done");
  endtask

  // one rotate code over edge operands and both carry values
  task automatic check_rot(input logic [3:0] code);
    logic [DATA_W-1:0] vals [4];
    logic [DATA_W-1:0] v, exp;
    logic right, thru, to_acc, fill, exp_c;
    vals = '{8'h81, 8'h5a, 8'h01, 8'h80};
    right = (code >= 4'h7);
    thru = (code == 4'h5) || (code == 4'h6) || (code == 4'h9) || (code == 4'ha);
    to_acc = !code[0];
    for (int i = 0; i < 4; i++) begin
      for (int c = 0; c < 2; c++) begin
        v = vals[i];
        fill = thru ? c[0] : (right ? v[0] : v[7]);
        exp = right ? {fill, v[7:1]} : {v[6:0], fill};
        exp_c = right ? v[0] : v[7];
        issue(code, v, 8'hc3, c[0], 13'h0000, 1'b0);
        chk(done_o, 16'h0001);
        chk(to_acc ? acc_data_o : mem_data_o, exp);
        chk({acc_we_o, mem_we_o}, {14'h0000, to_acc, !to_acc});
        chk({carry_we_o, stack_pop_o, illegal_o}, {13'h0000, thru, 2'b00});
        if (thru) begin
          chk(carry_o, exp_c);
        end
      end
    end
    $display("test rotate code %h done", code);
  endtask

  // two rotates issued on consecutive edges, strobes fall afterwards
  task automatic test_back_to_back();
    @(posedge clk_sys_i);
    op_valid <= 1'b1;
    op_code <= 4'h3;
    mem_operand <= 8'h80;
    @(posedge clk_sys_i);
    op_code <= 4'h8;
    mem_operand <= 8'h01;
    #1;
    chk({mem_we_o, acc_we_o, mem_data_o}, {8'h02, 8'h01});
    @(posedge clk_sys_i);
    op_valid <= 1'b0;
    #1;
    chk({mem_we_o, acc_we_o, acc_data_o}, {8'h01, 8'h80});
    chk(mem_data_o, 16'h0001);
    @(posedge clk_sys_i);
    #1;
    chk({done_o, acc_we_o, mem_we_o}, 16'h0000);
    $display("test back to back done");
  endtask

  task automatic test_ret_acc();
    issue(4'h1, 8'hff, 8'h3c, 1'b1, 13'h1abc, 1'b1);
    chk({stack_pop_o, pc_load_o, acc_we_o, done_o}, 16'h000f);
    chk(pc_o, 16'h1abc);
    chk(acc_data_o, 16'h003c);
    chk({carry_we_o, mem_we_o, gie_set_o, irq_take_o}, 16'h0000);
    $display("test return load acc done");
  endtask

  task automatic test_interrupt_return();
    issue(4'h2, 8'h00, 8'h00, 1'b0, 13'h0555, 1'b0);
    chk({stack_pop_o, pc_load_o, gie_set_o, irq_take_o}, 16'h000e);
    chk(pc_o, 16'h0555);
    chk({carry_we_o, acc_we_o, mem_we_o}, 16'h0000);
    issue(4'h2, 8'h00, 8'h00, 1'b1, 13'h1fff, 1'b1);
    chk({stack_pop_o, pc_load_o, gie_set_o, irq_take_o}, 16'h000b);
    chk(pc_o, 16'h1fff);
    chk({carry_we_o, acc_we_o, mem_we_o}, 16'h0000);
    $display("test interrupt return done");
  endtask

  // unknown codes only report themselves
  task automatic test_illegal();
    issue(4'hb, 8'h81, 8'h11, 1'b1, 13'h0123, 1'b0);
    chk({done_o, illegal_o, acc_we_o, mem_we_o, carry_we_o, stack_pop_o}, 16'h0030);
    issue(4'hf, 8'h81, 8'h11, 1'b1, 13'h0123, 1'b1);
    chk({done_o, illegal_o, gie_set_o, irq_take_o, pc_load_o}, 16'h0018);
    $display("test illegal done");
  endtask

  initial begin
    test_reset();
    check_rot(4'h3);
    check_rot(4'h4);
    check_rot(4'h5);
    check_rot(4'h6);
    check_rot(4'h7);
    check_rot(4'h8);
    check_rot(4'h9);
    check_rot(4'ha);
    test_back_to_back();
    test_ret_acc();
    test_interrupt_return();
    test_illegal();
    test_reset();
    end_sim();
  end
endmodule
